// ### core/sms_pkg.sv
package sms_pkg;

  // Datapath widths
  localparam int SAMPLE_W = 16;
  localparam int ENERGY_W = 40;
  localparam int LOG_W    = 10;
  localparam int LOG_FRAC = 4;
  localparam int SNR_W    = 16;
  localparam int SCORE_W  = 20;
  localparam int PROD_W   = 22;

  // Super-frame geometry
  localparam int SF_SAMPLES     = 1024;
  localparam int FRAME_SAMPLES  = 256;
  localparam int SUB_SAMPLES    = 64;
  localparam int FRAMES         = 4;
  localparam int SUBS_PER_FRAME = 4;
  localparam int TRIAL_COUNT    = 11;

  localparam logic [9:0] SF_LAST  = 10'h3ff;
  localparam logic [5:0] SUB_LAST = 6'h3f;
  localparam logic [3:0] TRIAL_FIRST = 4'h1;
  localparam logic [3:0] TRIAL_LAST  = 4'hb;

  // Per-frame mode codes, two bits each
  localparam logic [1:0] MODE_PREDICTIVE_TIME   = 2'h0;
  localparam logic [1:0] MODE_TRANSFORM_SHORT   = 2'h1;
  localparam logic [1:0] MODE_TRANSFORM_DOUBLE  = 2'h2;
  localparam logic [1:0] MODE_TRANSFORM_FULL    = 2'h3;

  // Support and look-ahead per candidate block
  localparam logic [10:0] SUPPORT_SHORT  = 11'h100;
  localparam logic [10:0] SUPPORT_DOUBLE = 11'h200;
  localparam logic [10:0] SUPPORT_FULL   = 11'h400;
  localparam logic [7:0]  LOOK_SHORT     = 8'h20;
  localparam logic [7:0]  LOOK_DOUBLE    = 8'h40;
  localparam logic [7:0]  LOOK_FULL      = 8'h80;

  // 20*log10(2) in Q8, turns log2 ratio into decibels
  localparam logic [10:0] DB_SCALE_Q8 = 11'h605;
  localparam int          DB_FRAC     = 8;

  typedef enum logic [2:0] {
    SMS_IDLE    = 3'b000,
    SMS_ISSUE   = 3'b001,
    SMS_COLLECT = 3'b010,
    SMS_DECIDE  = 3'b011,
    SMS_DONE    = 3'b100
  } sms_state_t;

endpackage : sms_pkg

// ### core/sms_seg_snr.sv
module sms_seg_snr
  import sms_pkg::*;
(
  input  wire logic                       core_clk,
  input  wire logic                       rst_n,
  input  wire logic                       clear,
  input  wire logic                       valid,
  input  wire logic signed [SAMPLE_W-1:0] weighted,
  input  wire logic signed [SAMPLE_W-1:0] synth,
  output logic                            snrValid,
  output logic signed [SNR_W-1:0]         snrValue
);

  logic [ENERGY_W-1:0]        sigEnergy;
  logic [ENERGY_W-1:0]        errEnergy;
  logic [5:0]                 subCount;
  logic [ENERGY_W-1:0]        next_sigEnergy;
  logic [ENERGY_W-1:0]        next_errEnergy;
  logic signed [SAMPLE_W:0]   diff;
  logic signed [LOG_W:0]      logRatio;
  logic signed [PROD_W-1:0]   dbProduct;

  // Coarse log2: leading-one position plus four bits below it
  function automatic logic [LOG_W-1:0] log2q(input logic [ENERGY_W-1:0] x);
    logic [5:0]          pos;
    logic [ENERGY_W-1:0] norm;
    pos = 6'h00;
    for (int i = 0; i < ENERGY_W; i++) begin
      if (x[i]) pos = 6'(i);
    end
    norm = x << (6'(ENERGY_W - 1) - pos);
    return {pos, norm[ENERGY_W-2 -: LOG_FRAC]};
  endfunction : log2q

  // Energies including the current sample
  always_comb begin
    diff           = (SAMPLE_W+1)'(weighted) - (SAMPLE_W+1)'(synth);
    next_sigEnergy = sigEnergy + ENERGY_W'(weighted * weighted);
    next_errEnergy = errEnergy + ENERGY_W'(diff * diff);
    logRatio       = $signed({1'b0, log2q(next_sigEnergy)})
                   - $signed({1'b0, log2q(next_errEnergy)});
    dbProduct      = PROD_W'(logRatio * $signed({1'b0, DB_SCALE_Q8}));
  end

  // Per-subframe accumulation; log of ratio avoids a divider
  always_ff @(posedge core_clk) begin
    if (!rst_n || clear) begin
      sigEnergy <= '0;
      errEnergy <= '0;
      subCount  <= 6'h00;
      snrValid  <= 1'b0;
      snrValue  <= '0;
    end else begin
      snrValid <= 1'b0;
      if (valid) begin
        if (subCount == SUB_LAST) begin
          sigEnergy <= '0;
          errEnergy <= '0;
          subCount  <= 6'h00;
          snrValid  <= 1'b1;
          snrValue  <= SNR_W'(dbProduct >>> DB_FRAC);
        end else begin
          sigEnergy <= next_sigEnergy;
          errEnergy <= next_errEnergy;
          subCount  <= subCount + 6'h01;
        end
      end
    end
  end

  // Helper: samples seen since the last score
  logic [6:0] seenCount;
  always_ff @(posedge core_clk) begin
    if (!rst_n || clear) begin
      seenCount <= 7'h00;
    end else if (snrValid) begin
      seenCount <= {6'h00, valid};
    end else begin
      seenCount <= seenCount + {6'h00, valid};
    end
  end

  AST_SUBFRAME_LEN: assert property (@(posedge core_clk) disable iff (!rst_n)
    snrValid |-> seenCount == 7'(SUB_SAMPLES))
    else $error("score issued without a full subframe");

endmodule : sms_seg_snr

// ### core/sms_core.sv
module sms_core
  import sms_pkg::*;
(
  input  wire logic                       core_clk,
  input  wire logic                       rst_n,
  input  wire logic                       sampleValid,
  input  wire logic                       rxCodesValid,
  input  wire logic [7:0]                 rxCodes,
  input  wire logic                       synValid,
  input  wire logic signed [SAMPLE_W-1:0] synWeighted,
  input  wire logic signed [SAMPLE_W-1:0] synSynth,
  output logic [1:0]                      inFrameIdx,
  output logic                            superFrameDone,
  output logic                            busy,
  output logic                            trialStart,
  output logic [3:0]                      trialNum,
  output logic [1:0]                      trialMode,
  output logic [1:0]                      trialFirstFrame,
  output logic [10:0]                     trialSupport,
  output logic [7:0]                      trialLookahead,
  output logic                            modesValid,
  output logic [7:0]                      modeCodes,
  output logic                            codeLegal,
  output logic                            rxCodesChecked,
  output logic                            rxCodesLegal
);

  sms_state_t                 state;
  logic [9:0]                 sampleCount;
  logic                       sfPending;
  logic [3:0]                 trialIndex;
  logic [4:0]                 subsSeen;
  logic [4:0]                 subsExpected;
  logic signed [SCORE_W-1:0]  trialSum;
  logic signed [SCORE_W-1:0]  keptSum;
  logic signed [SCORE_W-1:0]  frameScore [FRAMES];
  logic [1:0]                 frameCode  [FRAMES];
  logic [FRAMES-1:0]          spanMask;
  logic                       trialWins;
  logic [1:0]                 planFirst;
  logic [1:0]                 planMode;
  logic                       snrValid;
  logic signed [SNR_W-1:0]    snrValue;
  logic [7:0]                 keptCodes;
  logic [3:0]                 trialsRun;

  // A two-bit pair is fine when both are 2 or both below 2
  function automatic logic pair_ok(input logic [1:0] a, input logic [1:0] b);
    return ((a == MODE_TRANSFORM_DOUBLE) && (b == MODE_TRANSFORM_DOUBLE))
        || (!a[1] && !b[1]);
  endfunction : pair_ok

  // Full-block code stands alone; otherwise 5 x 5 pair options
  function automatic logic codes_legal(input logic [7:0] c);
    if (c == {4{MODE_TRANSFORM_FULL}}) begin
      return 1'b1;
    end
    return pair_ok(c[1:0], c[3:2]) && pair_ok(c[5:4], c[7:6]);
  endfunction : codes_legal

  // Trial plan: first frame and mode for each trial number
  function automatic logic [3:0] trial_plan(input logic [3:0] n);
    case (n)
      4'h1:    return {2'h0, MODE_PREDICTIVE_TIME};
      4'h2:    return {2'h0, MODE_TRANSFORM_SHORT};
      4'h3:    return {2'h1, MODE_PREDICTIVE_TIME};
      4'h4:    return {2'h1, MODE_TRANSFORM_SHORT};
      4'h5:    return {2'h0, MODE_TRANSFORM_DOUBLE};
      4'h6:    return {2'h2, MODE_PREDICTIVE_TIME};
      4'h7:    return {2'h2, MODE_TRANSFORM_SHORT};
      4'h8:    return {2'h3, MODE_PREDICTIVE_TIME};
      4'h9:    return {2'h3, MODE_TRANSFORM_SHORT};
      4'ha:    return {2'h2, MODE_TRANSFORM_DOUBLE};
      default: return {2'h0, MODE_TRANSFORM_FULL};
    endcase
  endfunction : trial_plan

  assign {planFirst, planMode} = trial_plan(trialIndex);

  // Sample counting splits the input into super-frames
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sampleCount    <= 10'h000;
      inFrameIdx     <= 2'h0;
      superFrameDone <= 1'b0;
    end else begin
      superFrameDone <= 1'b0;
      if (sampleValid) begin
        sampleCount    <= sampleCount + 10'h001;
        inFrameIdx     <= 2'((sampleCount + 10'h001) >> $clog2(FRAME_SAMPLES));
        superFrameDone <= (sampleCount == SF_LAST);
      end
    end
  end

  // Pending super-frame; a new arrival wins over the take
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sfPending <= 1'b0;
    end else if (superFrameDone) begin
      sfPending <= 1'b1;
    end else if (state == SMS_IDLE) begin
      sfPending <= 1'b0;
    end
  end

  // Scoring of the returned synthesis; cleared before trialStart so no sample is lost
  sms_seg_snr u_seg_snr (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clear    (state == SMS_ISSUE),
    .valid    (synValid && (state == SMS_COLLECT)),
    .weighted (synWeighted),
    .synth    (synSynth),
    .snrValid (snrValid),
    .snrValue (snrValue)
  );

  // Frames covered by the running trial
  always_comb begin
    subsExpected = 5'(SUBS_PER_FRAME);
    if (planMode == MODE_TRANSFORM_DOUBLE) begin
      subsExpected = 5'(2 * SUBS_PER_FRAME);
    end else if (planMode == MODE_TRANSFORM_FULL) begin
      subsExpected = 5'(FRAMES * SUBS_PER_FRAME);
    end
    keptSum = '0;
    for (int k = 0; k < FRAMES; k++) begin
      spanMask[k] = (3'(k) >= {1'b0, planFirst})
                 && (5'(k) < 5'(planFirst) + (subsExpected >> $clog2(SUBS_PER_FRAME)));
      if (spanMask[k]) keptSum = keptSum + frameScore[k];
    end
    // Same subframe count on both sides, so sums rank like means
    trialWins = (planMode == MODE_PREDICTIVE_TIME) || (trialSum > keptSum);
  end

  // Trial sequencer
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state      <= SMS_IDLE;
      trialIndex <= TRIAL_FIRST;
      subsSeen   <= 5'h00;
      trialSum   <= '0;
    end else begin
      unique case (state)
        SMS_IDLE: begin
          if (sfPending) begin
            trialIndex <= TRIAL_FIRST;
            state      <= SMS_ISSUE;
          end
        end
        SMS_ISSUE: begin
          subsSeen <= 5'h00;
          trialSum <= '0;
          state    <= SMS_COLLECT;
        end
        SMS_COLLECT: begin
          if (snrValid) begin
            trialSum <= trialSum + SCORE_W'(snrValue);
            subsSeen <= subsSeen + 5'h01;
            if (subsSeen + 5'h01 == subsExpected) state <= SMS_DECIDE;
          end
        end
        SMS_DECIDE: begin
          if (trialIndex == TRIAL_LAST) begin
            state <= SMS_DONE;
          end else begin
            trialIndex <= trialIndex + 4'h1;
            state      <= SMS_ISSUE;
          end
        end
        SMS_DONE: begin
          state <= SMS_IDLE;
        end
        default: begin
          state <= SMS_IDLE;
        end
      endcase
    end
  end

  // Kept choice per frame; a win writes the whole span
  for (genvar k = 0; k < FRAMES; k++) begin : g_frame
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        frameScore[k] <= '0;
        frameCode[k]  <= MODE_PREDICTIVE_TIME;
      end else if ((state == SMS_DECIDE) && spanMask[k] && trialWins) begin
        frameCode[k]  <= planMode;
        frameScore[k] <= (2'(k) == planFirst) ? trialSum : '0;
      end
    end
    assign keptCodes[2*k +: 2] = frameCode[k];
  end

  // Request towards the sub-encoders; trialStart pulses one cycle, the fields hold for the whole trial
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      trialStart      <= 1'b0;
      trialNum        <= 4'h0;
      trialMode       <= MODE_PREDICTIVE_TIME;
      trialFirstFrame <= 2'h0;
      trialSupport    <= SUPPORT_SHORT;
      trialLookahead  <= LOOK_SHORT;
      busy            <= 1'b0;
    end else begin
      trialStart <= (state == SMS_ISSUE);
      busy       <= (state != SMS_IDLE) || sfPending;
      if (state == SMS_ISSUE) begin
        trialNum        <= trialIndex;
        trialMode       <= planMode;
        trialFirstFrame <= planFirst;
        unique case (planMode)
          MODE_TRANSFORM_DOUBLE: begin
            trialSupport   <= SUPPORT_DOUBLE;
            trialLookahead <= LOOK_DOUBLE;
          end
          MODE_TRANSFORM_FULL: begin
            trialSupport   <= SUPPORT_FULL;
            trialLookahead <= LOOK_FULL;
          end
          MODE_PREDICTIVE_TIME, MODE_TRANSFORM_SHORT: begin
            trialSupport   <= SUPPORT_SHORT;
            trialLookahead <= LOOK_SHORT;
          end
        endcase
      end
    end
  end

  // Final codes: frame k sits in bits 2k+1:2k, one per packet
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      modesValid <= 1'b0;
      modeCodes  <= 8'h00;
      codeLegal  <= 1'b0;
    end else begin
      modesValid <= (state == SMS_DONE);
      if (state == SMS_DONE) begin
        modeCodes <= keptCodes;
        codeLegal <= codes_legal(keptCodes);
      end
    end
  end

  // Check of codes gathered from received packets
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rxCodesChecked <= 1'b0;
      rxCodesLegal   <= 1'b0;
    end else begin
      rxCodesChecked <= rxCodesValid;
      if (rxCodesValid) rxCodesLegal <= codes_legal(rxCodes);
    end
  end

  // Helper: trials issued for the current super-frame
  always_ff @(posedge core_clk) begin
    if (!rst_n || (state == SMS_IDLE)) begin
      trialsRun <= 4'h0;
    end else if (trialStart) begin
      trialsRun <= trialsRun + 4'h1;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  AST_SF_DONE_WRAP: assert property (
    superFrameDone |-> (inFrameIdx == 2'h0) && (sampleCount == 10'h000))
    else $error("super-frame end not on a frame 0 boundary");

  AST_SHORT_GEOMETRY: assert property (
    trialStart && (trialMode == MODE_TRANSFORM_SHORT)
      |-> (trialSupport == SUPPORT_SHORT) && (trialLookahead == LOOK_SHORT))
    else $error("short transform geometry wrong");

  AST_DOUBLE_GEOMETRY: assert property (
    trialStart && (trialMode == MODE_TRANSFORM_DOUBLE)
      |-> (trialSupport == SUPPORT_DOUBLE) && !trialFirstFrame[0])
    else $error("double transform geometry or pairing wrong");

  AST_FULL_GEOMETRY: assert property (
    trialStart && (trialMode == MODE_TRANSFORM_FULL)
      |-> (trialLookahead == LOOK_FULL) && (trialNum == TRIAL_LAST))
    else $error("full transform trial misplaced");

  AST_FIRST_TRIAL: assert property (
    trialStart && (trialNum == TRIAL_FIRST)
      |-> (trialMode == MODE_PREDICTIVE_TIME) && (trialFirstFrame == 2'h0))
    else $error("first trial is not predictive on frame 0");

  AST_ELEVEN_TRIALS: assert property (
    modesValid |-> (trialsRun == 4'(TRIAL_COUNT)))
    else $error("decision issued without eleven trials");

  AST_PAIR_DOUBLE: assert property (
    modesValid && (modeCodes[1:0] == MODE_TRANSFORM_DOUBLE)
      |-> (modeCodes[3:2] == MODE_TRANSFORM_DOUBLE))
    else $error("double code on frame 0 without frame 1");

  AST_PAIR_DOUBLE_HIGH: assert property (
    modesValid && (modeCodes[5:4] == MODE_TRANSFORM_DOUBLE)
      |-> (modeCodes[7:6] == MODE_TRANSFORM_DOUBLE))
    else $error("double code on frame 2 without frame 3");

  AST_TENTH_TRIAL: assert property (
    trialStart && (trialNum == 4'ha)
      |-> (trialMode == MODE_TRANSFORM_DOUBLE) && (trialFirstFrame == 2'h2))
    else $error("tenth trial is not the double block on frames 2 and 3");

  AST_FULL_ALONE: assert property (
    modesValid && (modeCodes[7:6] == MODE_TRANSFORM_FULL)
      |-> (modeCodes == {4{MODE_TRANSFORM_FULL}}))
    else $error("full code mixed with others");

  AST_LEGAL_OUT: assert property (
    modesValid |-> codeLegal)
    else $error("selected combination not legal");

  AST_TIE_KEEPS: assert property (
    (state == SMS_DECIDE) && (planMode != MODE_PREDICTIVE_TIME)
      && (trialSum == keptSum) |=> $stable(keptCodes))
    else $error("tie replaced the kept candidate");

endmodule : sms_core

// ### verif/sms_syn_model.sv
module sms_syn_model
  import sms_pkg::*;
(
  input  wire logic                   core_clk,
  input  wire logic                   trialStart,
  input  wire logic [3:0]             trialNum,
  input  wire logic [10:0]            trialSupport,
  input  wire logic [10:0][7:0]       trialErr,
  output logic                        synValid,
  output logic signed [SAMPLE_W-1:0]  synWeighted,
  output logic signed [SAMPLE_W-1:0]  synSynth
);
  timeunit 1ns;
  timeprecision 1ps;

  int unsigned remain;
  logic [7:0]  err;

  initial begin
    remain      = 0;
    err         = 8'h00;
    synValid    = 1'b0;
    synWeighted = 16'sh1000;
    synSynth    = 16'sh0fff;
  end

  // One block of support samples per trial; error size picks the trial's score
  // Idle data lines toggle so a stale sample can never pass for a valid one
  always @(negedge core_clk) begin
    if (trialStart && remain == 0) begin
      remain = trialSupport;
      err    = trialErr[trialNum - 4'h1];
    end
    if (remain > 0) begin
      synValid    <= 1'b1;
      synWeighted <= 16'sh1000;
      synSynth    <= 16'sh1000 - $signed({8'h00, err});
      remain      = remain - 1;
    end else begin
      synValid    <= 1'b0;
      synWeighted <= ~synWeighted;
      synSynth    <= ~synSynth;
    end
  end
endmodule : sms_syn_model

// ### verif/tb_top.sv
module tb_top
  import sms_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic core_clk, rst_n, sampleValid, rxCodesValid, synValid;
  logic [7:0] rxCodes, modeCodes, trialLookahead;
  logic signed [SAMPLE_W-1:0] synWeighted, synSynth;
  logic [1:0] inFrameIdx, trialMode, trialFirstFrame;
  logic superFrameDone, busy, trialStart, modesValid, codeLegal;
  logic rxCodesChecked, rxCodesLegal;
  logic [3:0] trialNum;
  logic [10:0] trialSupport;
  logic [10:0][7:0] trialErr;
  int num_errors, check_count;

  // Trial order: high nibble first frame, low nibble mode
  localparam logic [7:0] ORDER_TAB [11] = '{8'h00, 8'h01, 8'h10, 8'h11, 8'h02,
    8'h20, 8'h21, 8'h30, 8'h31, 8'h22, 8'h03};

  sms_core sms_core_i (.core_clk(core_clk), .rst_n(rst_n), .sampleValid(sampleValid),
    .rxCodesValid(rxCodesValid), .rxCodes(rxCodes), .synValid(synValid),
    .synWeighted(synWeighted), .synSynth(synSynth), .inFrameIdx(inFrameIdx),
    .superFrameDone(superFrameDone), .busy(busy), .trialStart(trialStart),
    .trialNum(trialNum), .trialMode(trialMode), .trialFirstFrame(trialFirstFrame),
    .trialSupport(trialSupport), .trialLookahead(trialLookahead),
    .modesValid(modesValid), .modeCodes(modeCodes), .codeLegal(codeLegal),
    .rxCodesChecked(rxCodesChecked), .rxCodesLegal(rxCodesLegal));

  sms_syn_model sms_syn_model_i (.core_clk(core_clk), .trialStart(trialStart),
    .trialNum(trialNum), .trialSupport(trialSupport), .trialErr(trialErr),
    .synValid(synValid), .synWeighted(synWeighted), .synSynth(synSynth));

  // Free-running 125 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wrap_up();
    $display("checks %0d, errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up

  // Bounded wait for trialStart (which 0) or modesValid (which 1)
  task automatic wait_for(input int which);
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while ((which == 0 ? trialStart : modesValid) !== 1'b1 && n < 2000);
    if (n >= 2000) begin
      chk(16'h0000, 16'h0001);
      wrap_up();
    end
  endtask : wait_for

  // Pair legality: both 2 or neither, and no 3
  function automatic logic pair_ok(input logic [1:0] a, input logic [1:0] b);
    return a != 2'h3 && b != 2'h3 && ((a == 2'h2) == (b == 2'h2));
  endfunction : pair_ok

  task automatic check_reset();
    chk(trialSupport, 16'h0100);
    chk(trialLookahead, 16'h0020);
    chk({busy, modesValid, trialStart, superFrameDone, rxCodesChecked}, 16'h0000);
    chk(modeCodes, 16'h0000);
  endtask : check_reset

  // Every code word back to back, counting the legal ones
  task automatic scan_codes();
    int legalCount;
    logic exp;
    legalCount = 0;
    for (int i = 0; i < 256; i++) begin
      @(negedge core_clk);
      rxCodesValid = 1'b1;
      rxCodes      = i[7:0];
      @(posedge core_clk);
      #1;
      exp = (rxCodes == 8'hff) || (pair_ok(rxCodes[1:0], rxCodes[3:2])
            && pair_ok(rxCodes[5:4], rxCodes[7:6]));
      legalCount += exp;
      chk(rxCodesChecked, 16'h0001);
      chk(rxCodesLegal, exp);
    end
    @(negedge core_clk);
    rxCodesValid = 1'b0;
    chk(legalCount, 16'd26);
  endtask : scan_codes

  // One super-frame of input, then all trials with the given error per trial
  task automatic run_superframe(input logic [10:0][7:0] errs, input logic [7:0] expCodes);
    logic [1:0] m;
    @(negedge core_clk);
    trialErr = errs;
    for (int i = 0; i < 1024; i++) begin
      @(negedge core_clk);
      sampleValid = 1'b1;
      chk(inFrameIdx, i / 256);
    end
    @(negedge core_clk);
    sampleValid = 1'b0;
    chk(superFrameDone, 16'h0001);
    chk(inFrameIdx, 16'h0000);
    for (int t = 0; t < 11; t++) begin
      wait_for(0);
      m = ORDER_TAB[t][1:0];
      chk(busy, 16'h0001);
      chk(modesValid, 16'h0000);
      chk(trialNum, t + 1);
      chk(trialMode, m);
      chk(trialFirstFrame, ORDER_TAB[t][5:4]);
      chk(trialSupport, 16'h0100 << (m == 2'h0 ? 0 : m - 1));
      if (m != 2'h0) begin
        chk(trialLookahead, 16'h0020 << (m - 1));
      end
    end
    wait_for(1);
    chk(modeCodes, expCodes);
    chk(codeLegal, 16'h0001);
  endtask : run_superframe

  initial begin
    num_errors   = 0;
    check_count  = 0;
    rst_n        = 1'b0;
    sampleValid  = 1'b0;
    rxCodesValid = 1'b0;
    rxCodes      = 8'h00;
    trialErr     = '0;
    repeat (12) @(negedge core_clk);
    check_reset();
    rst_n = 1'b1;
    scan_codes();
    // Mixed result: predictive, short, then double pair wins over tie kept
    run_superframe({8'h80, 8'h01, 8'h04, 8'h04, 8'h04, 8'h04, 8'h80, 8'h04,
                    8'h80, 8'h80, 8'h04}, 8'ha4);
    // All scores equal: held candidates survive every comparison
    run_superframe({11{8'h04}}, 8'h00);
    // Full block best on the last trial
    run_superframe({8'h01, {10{8'h04}}}, 8'hff);
    wrap_up();
  end
endmodule : tb_top
